// [verilog/pwr_top.v]
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`include "pwr_defines.vh"
// Operation
// [RULE1] Software selects a 13 MHz or a 32.768 kHz counting source for the pulse generator.
// [RULE2] The selected source is divided by a 12-bit setting, down to one in 4096, per cycle.
// [RULE3] Slow source gives 8 Hz to 16.384 kHz, fast source 3.17 kHz to 6.5 MHz.
// [RULE4] The on/off ratio per cycle is programmable from always off to always on.
// [RULE5] Software selects whether the active part of the output is low or high.
// [RULE6] A rhythm counter steps down every 50 ms, twenty steps making a 1 s period.
// [RULE7] A 20-bit pattern register gives one bit per rhythm step, used during that step.
// [RULE8] A zero pattern bit for the current step forces the output to the masked level.
// [RULE9] An interrupt can be raised once per rhythm period, on the 1 s boundary.
// [RULE10] The masked level is the inactive level and the rhythm counter wraps continuously.
// [RULE11] After reset both counters are stopped and the output rests inactive until enabled; PWM_OUT resets to 0, the active level, until the first clock.
module pwr_top (
  input wire MCLK,
  input wire ARST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  output reg PWM_OUT,
  output reg IRQ
);
  // ****************************************
  // Source ticks
  // ****************************************
  // Fractional accumulators: phase step = f_src, wrap at f_clk
  localparam [25:0] CLK_HZ = 26'h2FAF080;
  localparam [25:0] FAST_HZ = 26'h0C65D40;
  localparam [25:0] SLOW_HZ = 26'h0008000;
  localparam [21:0] STEP_CYC = `PWR_STEP_CYC;
  localparam [4:0] LAST_STEP = 5'd19;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_MASK = 3'b100;

  reg [3:0] ctrl_q;
  reg [11:0] div_q;
  reg [12:0] duty_q;
  reg [19:0] pattern_q;
  reg [1:0] status_q;
  reg [1:0] mask_q;
  reg [25:0] fast_acc_q;
  reg [25:0] slow_acc_q;
  reg fast_tick_q;
  reg slow_tick_q;
  reg [11:0] cnt_q;
  reg [21:0] step_cnt_q;
  reg [4:0] step_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg pwm_raw;
  reg period_evt;
  reg cycle_evt;

  wire en = ctrl_q[`PWR_CTRL_EN];
  wire act_high = ctrl_q[`PWR_CTRL_ACT_HIGH];
  wire rhy_en = ctrl_q[`PWR_CTRL_RHY_EN];
  wire [25:0] fast_sum = fast_acc_q + FAST_HZ;
  wire [25:0] slow_sum = slow_acc_q + SLOW_HZ;
  wire src_tick = ctrl_q[`PWR_CTRL_SLOW] ? slow_tick_q : fast_tick_q; // [RULE1]
  // Write lands at the edge where the master sees ready
  wire wr = PSEL & PENABLE & PWRITE & PREADY;
  wire rd_setup = PSEL & ~PENABLE;
  wire addr_ok = (PADDR <= `PWR_OFF_STATE) && (PADDR[1:0] == 2'b00);

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fast_acc_q <= 26'h0000000;
      slow_acc_q <= 26'h0000000;
      fast_tick_q <= 1'b0;
      slow_tick_q <= 1'b0;
    end else begin
      fast_tick_q <= (fast_sum >= CLK_HZ);
      slow_tick_q <= (slow_sum >= CLK_HZ);
      fast_acc_q <= (fast_sum >= CLK_HZ) ? fast_sum - CLK_HZ : fast_sum;
      slow_acc_q <= (slow_sum >= CLK_HZ) ? slow_sum - CLK_HZ : slow_sum;
    end
  end

  // ****************************************
  // Pulse generator
  // ****************************************
  // Period is div_q + 1 source ticks (1 to 4096); on-time is duty_q ticks,
  // duty_q above div_q means always on, zero means always off.
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_q <= 12'h000;
    end else if (!en) begin
      cnt_q <= 12'h000; // [RULE11]
    end else if (src_tick) begin
      if (cnt_q >= div_q) begin
        cnt_q <= 12'h000; // [RULE2] [RULE3]
      end else begin
        cnt_q <= cnt_q + 12'h001;
      end
    end
  end

  always @* begin
    pwm_raw = ({1'b0, cnt_q} < duty_q); // [RULE4]
  end

  // ****************************************
  // Rhythm counter
  // ****************************************
  always @* begin
    period_evt = en & rhy_en & (step_cnt_q == STEP_CYC - 22'h000001) & (step_q == 5'd0);
    cycle_evt = en & src_tick & (cnt_q >= div_q);
  end

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      step_cnt_q <= 22'h000000;
      step_q <= LAST_STEP;
    end else if (!(en & rhy_en)) begin
      step_cnt_q <= 22'h000000; // [RULE11]
      step_q <= LAST_STEP;
    end else if (step_cnt_q == STEP_CYC - 22'h000001) begin
      step_cnt_q <= 22'h000000; // [RULE6]
      // Counts down; wraps from step 0 back to the top
      step_q <= (step_q == 5'd0) ? LAST_STEP : step_q - 5'd1; // [RULE10]
    end else begin
      step_cnt_q <= step_cnt_q + 22'h000001;
    end
  end

  // ****************************************
  // Output state machine
  // ****************************************
  always @* begin
    case (state_q)
      ST_IDLE: begin
        // Go straight to mask when the step's pattern bit is zero, so no stray pulse leaks on enable
        if (!en) begin
          state_d = ST_IDLE;
        end else if (rhy_en && !pattern_q[step_q]) begin
          state_d = ST_MASK; // [RULE8]
        end else begin
          state_d = ST_RUN;
        end
      end
      ST_RUN, ST_MASK: begin
        if (!en) begin
          state_d = ST_IDLE;
        end else if (rhy_en && !pattern_q[step_q]) begin
          state_d = ST_MASK; // [RULE7] [RULE8]
        end else begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_IDLE;
      PWM_OUT <= 1'b0;
    end else begin
      state_q <= state_d;
      case (state_d)
        // Polarity flips both active level and masked level together
        ST_RUN: PWM_OUT <= pwm_raw ~^ act_high; // [RULE5]
        ST_MASK: PWM_OUT <= ~act_high; // [RULE8] [RULE10]
        default: PWM_OUT <= ~act_high; // [RULE11]
      endcase
    end
  end

  // ****************************************
  // APB slave and interrupt
  // ****************************************
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= `PWR_RST_CTRL;
      div_q <= `PWR_RST_DIV;
      duty_q <= `PWR_RST_DUTY;
      pattern_q <= `PWR_RST_PATTERN;
      status_q <= 2'b00;
      mask_q <= 2'b00;
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      // No wait state: ready in the cycle after setup
      PREADY <= rd_setup;
      PSLVERR <= rd_setup & ~addr_ok;
      if (wr && addr_ok) begin
        case (PADDR)
          `PWR_OFF_CTRL: ctrl_q <= PWDATA[3:0];
          `PWR_OFF_DIV: div_q <= PWDATA[11:0];
          `PWR_OFF_DUTY: duty_q <= PWDATA[12:0];
          `PWR_OFF_PATTERN: pattern_q <= PWDATA[19:0];
          `PWR_OFF_MASK: mask_q <= PWDATA[1:0];
          default: ;
        endcase
      end
      // Set wins over write-one-to-clear
      status_q[0] <= period_evt | (status_q[0] &
        ~(wr && PADDR == `PWR_OFF_STATUS && PWDATA[0])); // [RULE9]
      status_q[1] <= cycle_evt | (status_q[1] &
        ~(wr && PADDR == `PWR_OFF_STATUS && PWDATA[1]));
      IRQ <= |(status_q & mask_q);
      if (rd_setup && !PWRITE) begin
        case (PADDR)
          `PWR_OFF_CTRL: PRDATA <= {28'h0000000, ctrl_q};
          `PWR_OFF_DIV: PRDATA <= {20'h00000, div_q};
          `PWR_OFF_DUTY: PRDATA <= {19'h00000, duty_q};
          `PWR_OFF_PATTERN: PRDATA <= {12'h000, pattern_q};
          `PWR_OFF_STATUS: PRDATA <= {30'h00000000, status_q};
          `PWR_OFF_MASK: PRDATA <= {30'h00000000, mask_q};
          `PWR_OFF_STATE: PRDATA <= {12'h000, state_q, step_q, cnt_q};
          default: PRDATA <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // pwr_top

// [verilog/pwr_defines.vh]
`ifndef PWR_DEFINES_VH
`define PWR_DEFINES_VH
// ****************************************
// Register byte offsets
// ****************************************
`define PWR_OFF_CTRL 12'h000
`define PWR_OFF_DIV 12'h004
`define PWR_OFF_DUTY 12'h008
`define PWR_OFF_PATTERN 12'h00C
`define PWR_OFF_STATUS 12'h010
`define PWR_OFF_MASK 12'h014
`define PWR_OFF_STATE 12'h018
// ****************************************
// Control fields
// ****************************************
`define PWR_CTRL_EN 0
`define PWR_CTRL_SLOW 1
`define PWR_CTRL_ACT_HIGH 2
`define PWR_CTRL_RHY_EN 3
// ****************************************
// Reset values and widths
// ****************************************
`define PWR_DIV_W 12
`define PWR_PAT_W 20
`define PWR_RST_CTRL 4'h0
`define PWR_RST_DIV 12'hFFF
`define PWR_RST_DUTY 13'h0000
`define PWR_RST_PATTERN 20'hFFFFF
// ****************************************
// Timing
// ****************************************
`define PWR_CLK_HZ 50000000
`define PWR_FAST_HZ 13000000
`define PWR_SLOW_HZ 32768
`define PWR_STEP_MS 50
`define PWR_STEPS 20
// 50 ms at 50 MHz, sized to the step counter
`define PWR_STEP_CYC 22'h2625A0
`endif

// [verif/pwr_chk_properties.sv]
`timescale 1ns/100ps
module pwr_chk (
  input wire MCLK, ARST_N, PSEL, PENABLE, PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PRDATA,
  input wire PREADY, PSLVERR, PWM_OUT, IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  reg wrote_q;
  wire setup = PSEL && !PENABLE;
  wire bad = PADDR > 12'h018 || PADDR[1:0] != 2'h0;
  // Output must rest inactive until software first touches control
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) wrote_q <= 1'b0;
    else if (PSEL && PENABLE && PWRITE && PADDR == 12'h000) wrote_q <= 1'b1;
  end
  AST_RDY: assert property (setup |=> PREADY) else $error("ready missing");
  AST_ONE: assert property (!setup |=> !PREADY) else $error("stray ready");
  AST_ERR: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  AST_BAD: assert property (setup && bad |=> PSLVERR) else $error("bad address accepted");
  AST_GOOD: assert property (setup && !bad |=> !PSLVERR) else $error("good address refused");
  AST_ERR_RD: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("bad rdata");
  AST_IRQ: assert property ($fell(IRQ) |-> $past(PSEL && PENABLE && PWRITE, 2)) else $error("irq");
  AST_IDLE: assert property (!wrote_q |=> PWM_OUT) else $error("idle level");
  cover property (PSLVERR);
  cover property ($fell(IRQ));
  cover property (wrote_q && $rose(PWM_OUT));
endmodule // pwr_chk
bind pwr_top pwr_chk u_chk (.MCLK(MCLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PWM_OUT(PWM_OUT), .IRQ(IRQ));

// [verif/testbench.sv]
`timescale 1ns/100ps
module testbench;
  reg MCLK = 1'b0;
  reg ARST_N = 1'b0;
  reg PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  reg [11:0] PADDR = 12'h000;
  reg [31:0] PWDATA = 32'h0;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, PWM_OUT, IRQ;
  integer n_mismatch = 0, checks = 0, hi;
  pwr_top uut (.MCLK(MCLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PWM_OUT(PWM_OUT), .IRQ(IRQ));
  always #10 MCLK = ~MCLK;
  initial begin
    repeat (5000) @(posedge MCLK);
    n_mismatch = n_mismatch + 1;
    close_out;
  end
  task close_out;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input [63:0] nm, input [31:0] s, input [31:0] e);
    checks = checks + 1;
    if (s !== e) n_mismatch = n_mismatch + 1;
    if (s !== e) $display("[FAIL] %0s exp %h seen %h", nm, e, s);
  endtask
  // For reads d is the expected word
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1) @(posedge MCLK);
    // Still the sampled values, before this edge's updates land
    if (!w) chk("rdata", PRDATA, d);
    chk("slverr", {31'h0, PSLVERR}, {31'h0, a > 12'h018 || a[1:0] != 2'h0});
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Source ticks jitter by one clock, so the half-duty count is judged coarsely
  task meas;
    repeat (20) @(posedge MCLK);
    hi = 0;
    repeat (200) @(posedge MCLK) hi = hi + PWM_OUT;
  endtask
  task t_regs;
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b0, 12'h004, 32'hFFF);
    chk("idle", {31'h0, PWM_OUT}, 32'h1);
    apb(1'b0, 12'h00C, 32'hFFFFF);
    apb(1'b1, 12'h00C, 32'hABC12345);
    apb(1'b0, 12'h00C, 32'h12345);
    apb(1'b0, 12'h01C, 32'h0);
    apb(1'b0, 12'h006, 32'h0);
  endtask
  task t_out;
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b1, 12'h008, 32'h2);
    apb(1'b1, 12'h000, 32'h5);
    meas;
    chk("half", {31'h0, hi > 60 && hi < 140}, 32'h1);
    apb(1'b1, 12'h008, 32'hFFF);
    meas;
    chk("full", hi, 32'hC8);
    apb(1'b1, 12'h000, 32'hD);
    apb(1'b1, 12'h00C, 32'h0);
    meas;
    chk("masked", hi, 32'h0);
  endtask
  task t_irq;
    apb(1'b1, 12'h000, 32'h5);
    apb(1'b0, 12'h010, 32'h2);
    chk("irq", {31'h0, IRQ}, 32'h0);
    apb(1'b1, 12'h014, 32'h2);
    apb(1'b1, 12'h000, 32'h0);
    chk("irq", {31'h0, IRQ}, 32'h1);
    apb(1'b1, 12'h010, 32'h2);
    apb(1'b0, 12'h010, 32'h0);
    chk("irq", {31'h0, IRQ}, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge MCLK);
    ARST_N <= 1'b1;
    t_regs;
    t_out;
    t_irq;
    close_out;
  end
endmodule // testbench
